// >>> amt_pkg.sv
// amt_pkg: register offsets, field positions, reset values and timing
// for the alert mask and thermal timer block.
// assumes a 100 MHz core clock.
package amt_pkg;
	localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
	localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
	localparam logic [7:0] ADDR_ALERT_MASK_ONE = 8'h74;
	localparam logic [7:0] ADDR_ALERT_MASK_TWO = 8'h75;
	localparam logic [7:0] ADDR_CONFIG_THREE = 8'h78;
	localparam logic [7:0] ADDR_THERMAL_TIMER = 8'h79;
	localparam logic [7:0] ADDR_TIMER_LIMIT = 8'h7A;
	localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h7D;

	localparam int SUMMARY_BIT = 7;
	localparam int THERMAL_EVENT_PIN_OR_25V_BIT = 0;
	localparam int FOURTH_FAN_BIT = 5;
	localparam int OVERTEMP_BIT = 1;
	localparam int CFG3_ALERT_ON_PIN_BIT = 0;
	localparam int CFG3_THERMAL_EN_BIT = 1;
	localparam int CFG3_FULL_SPEED_ON_THERMAL_INPUT_BIT = 2;

	localparam logic [7:0] ALERT_MASK_ONE_RST = 8'h00;
	localparam logic [7:0] ALERT_MASK_TWO_RST = 8'h00;
	localparam logic [7:0] CONFIG_THREE_RST = 8'h00;
	localparam logic [7:0] TIMER_LIMIT_RST = 8'h00;
	localparam logic [7:0] CONFIG_FOUR_RST = 8'h00;
	localparam logic [7:0] TIMER_FULL = 8'hFF;

	typedef enum logic [1:0] {
		AMT_FN_TACH = 2'h0,
		AMT_FN_THERMAL = 2'h1,
		AMT_FN_GPIO = 2'h2,
		AMT_FN_ALERT = 2'h3
	} amt_pin_fn_e;

	localparam real CLK_PERIOD_NS = 10.0;
	localparam real TIMER_LSB_MS = 22.76;
	localparam int TIMER_LSB_CYCLES = int'(TIMER_LSB_MS * 1.0e6 / CLK_PERIOD_NS);
endpackage

// >>> amt_thermal_timer.sv
// amt_thermal_timer: cumulative, saturating assertion timer, cleared by read.
// assumes the assertion level and read strobe are synchronous to clk_in.
`timescale 1ns/1ps
module amt_thermal_timer #(
	parameter int LSB_CYCLES = amt_pkg::TIMER_LSB_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic asserted_in,
	input wire logic read_clr_in,
	input wire logic [7:0] limit_in,
	output logic [7:0] value_out,
	output logic exceed_out
);
	import amt_pkg::*;

	logic [31:0] pre_r;
	logic [31:0] pre_nxt;
	logic [7:0] units_r;
	logic [7:0] units_nxt;
	logic seen_r;
	logic seen_nxt;
	logic [7:0] value_r;
	logic [7:0] value_nxt;

	always_comb begin
		pre_nxt = pre_r;
		units_nxt = units_r;
		seen_nxt = seen_r;
		// RULE_18 RULE_20 clear on read
		if (read_clr_in) begin
			pre_nxt = 32'h0000_0000;
			units_nxt = 8'h00;
			seen_nxt = asserted_in;
		// RULE_15 RULE_16 accumulate and hold
		end else if (asserted_in) begin
			seen_nxt = 1'b1;
			if (units_r != TIMER_FULL) begin
				if (pre_r == 32'(LSB_CYCLES - 1)) begin
					pre_nxt = 32'h0000_0000;
					units_nxt = units_r + 8'h01;
				end else begin
					pre_nxt = pre_r + 32'h0000_0001;
				end
			end
		end
		// RULE_17 first assertion flag
		value_nxt = (units_nxt == 8'h00) ? {7'h00, seen_nxt} : units_nxt;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pre_r <= 32'h0000_0000;
			units_r <= 8'h00;
			seen_r <= 1'b0;
			value_r <= 8'h00;
		end else if (ce_in) begin
			pre_r <= pre_nxt;
			units_r <= units_nxt;
			seen_r <= seen_nxt;
			value_r <= value_nxt;
		end
	end

	assign value_out = value_r;
	assign exceed_out = value_r > limit_in;

	property p_saturate;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && !read_clr_in && value_r == 8'hFF) |=> value_r == 8'hFF;
	endproperty
	a_saturate: assert property (p_saturate) else $error("timer left full scale"); // RULE_16

	property p_read_idle;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && read_clr_in && !asserted_in) |=> value_r == 8'h00;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read did not clear"); // RULE_18

	property p_read_busy;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && read_clr_in && asserted_in) |=> value_r == 8'h01;
	endproperty
	a_read_busy: assert property (p_read_busy) else $error("read in assertion not 1"); // RULE_20

	property p_pause;
		@(posedge clk_in) disable iff (rst_in)
		(!asserted_in && !read_clr_in) |=> $stable(value_r);
	endproperty
	a_pause: assert property (p_pause) else $error("timer moved while idle"); // RULE_15
endmodule

// >>> amt_alert_ctrl.sv
// amt_alert_ctrl: sticky status, alert masking, pin function select,
// thermal full_speed_on_thermal_input and the thermal assertion timer.
// assumes an SMBus engine presents one-cycle read and write strobes with
// a register offset; limit comparators feed level fault inputs.
// Contract
// RULE_01: status bit latches on fault, clears only when fault gone and read.
// RULE_02: alert stays low while out of limit and until status read.
// RULE_03: overtemperature flag follows its condition, never latches.
// RULE_04: mask bit blocks alert only; status bit still sets.
// RULE_05: mask one: bit7 second-status summary, bits 6..0 per channel.
// RULE_06: mask two: diodes, fans three..one, overtemperature, twelve volt.
// RULE_07: mask two bit5 masks fourth fan, thermal or io event.
// RULE_08: alert output disabled after reset; two pins may carry it.
// RULE_09: config three bit0 picks alert or second fan drive on pin.
// RULE_10: config four bits 1..0 pick shared pin function.
// RULE_11: thermal enable makes dedicated pin thermal; shared pin if selected.
// RULE_12: thermal disabled: dedicated pin is 2.5 V, shared thermal off.
// RULE_13: full_speed_on_thermal_input bit forces full fans while thermal pin held low.
// RULE_14: full_speed_on_thermal_input applies only to fans already running.
// RULE_15: timer counts during assertion, pauses otherwise, accumulates.
// RULE_16: timer stops at full scale until read.
// RULE_17: bit0 flags first assertion, then counts 22.76 ms units.
// RULE_18: reading timer clears it.
// RULE_19: host clears shared status bit after timer read when exceeded.
// RULE_20: read during assertion clears, sets bit0, keeps counting.
// RULE_21: read during assertion with zero limit sets shared flag again.
// RULE_22: host masks on alert, polls, unmasks once status clears.
// RULE_23: timer above limit sets shared status flag and alert.
// RULE_24: status one bit7 set while any status two bit set.
// RULE_25: alert driven low while any unmasked status bit set.
`timescale 1ns/1ps
module amt_alert_ctrl #(
	parameter int LSB_CYCLES = amt_pkg::TIMER_LSB_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic [6:0] fault_one_in,
	input wire logic [7:0] fault_two_in,
	input wire logic thermal_event_pin_n_in,
	input wire logic shared_pin_in,
	input wire logic second_fan_drive_in,
	input wire logic fan_running_in,
	output logic alert_pin_out,
	output logic alert_pin_oe_n_out,
	output logic shared_pin_out,
	output logic shared_pin_oe_n_out,
	output logic full_speed_on_thermal_input_out,
	output amt_pkg::amt_pin_fn_e shared_pin_function_field_out
);
	import amt_pkg::*;

	logic [6:0] status_one_r;
	logic [6:0] status_one_nxt;
	logic [7:0] status_two_r;
	logic [7:0] status_two_nxt;
	logic [7:0] alert_mask_one_r;
	logic [7:0] alert_mask_one_nxt;
	logic [7:0] alert_mask_two_r;
	logic [7:0] alert_mask_two_nxt;
	logic [7:0] config_three_r;
	logic [7:0] config_three_nxt;
	logic [7:0] timer_limit_r;
	logic [7:0] timer_limit_nxt;
	logic [7:0] config_four_r;
	logic [7:0] config_four_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic alert_r;
	logic alert_nxt;
	logic full_speed_on_thermal_input_r;
	logic full_speed_on_thermal_input_nxt;
	logic alert_pin_r;
	logic alert_pin_nxt;
	logic alert_oe_n_r;
	logic alert_oe_n_nxt;
	logic shared_oe_n_r;
	logic shared_oe_n_nxt;

	logic thermal_en;
	logic shared_thermal;
	logic thermal_asserted;
	logic timer_read;
	logic timer_exceed;
	logic [7:0] timer_value;
	logic [6:0] src_one;
	logic [7:0] src_two;
	logic summary;
	amt_pin_fn_e pin_fn;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = addr == offset;
	endfunction

	assign pin_fn = amt_pin_fn_e'(config_four_r[1:0]);
	// RULE_11 RULE_12 thermal pin routing
	assign thermal_en = config_three_r[CFG3_THERMAL_EN_BIT];
	assign shared_thermal = thermal_en && pin_fn == AMT_FN_THERMAL;
	assign thermal_asserted = thermal_en
		&& (!thermal_event_pin_n_in || (shared_thermal && !shared_pin_in));
	assign timer_read = reg_rd_in && hit(reg_addr_in, ADDR_THERMAL_TIMER);

	amt_thermal_timer #(
		.LSB_CYCLES(LSB_CYCLES)
	) u_timer (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.asserted_in(thermal_asserted),
		.read_clr_in(timer_read),
		.limit_in(timer_limit_r),
		.value_out(timer_value),
		.exceed_out(timer_exceed)
	);

	always_comb begin
		src_one = fault_one_in;
		src_two = fault_two_in;
		// RULE_23 RULE_21 timer limit event feeds the active thermal pin's flag
		if (thermal_en && !shared_thermal) begin
			src_one[THERMAL_EVENT_PIN_OR_25V_BIT] = timer_exceed;
		end
		if (shared_thermal) begin
			src_two[FOURTH_FAN_BIT] = timer_exceed;
		end else if (pin_fn == AMT_FN_GPIO) begin
			src_two[FOURTH_FAN_BIT] = shared_pin_in;
		end
	end

	// RULE_24 summary of second status
	assign summary = |status_two_r;

	always_comb begin
		status_one_nxt = src_one;
		status_two_nxt = src_two;
		// RULE_01 sticky, set wins over read clear
		if (!(reg_rd_in && hit(reg_addr_in, ADDR_STATUS_ONE))) begin
			status_one_nxt = src_one | status_one_r;
		end
		if (!(reg_rd_in && hit(reg_addr_in, ADDR_STATUS_TWO))) begin
			status_two_nxt = src_two | status_two_r;
		end
		// RULE_03 overtemperature follows its condition
		status_two_nxt[OVERTEMP_BIT] = src_two[OVERTEMP_BIT];
	end

	always_comb begin
		alert_mask_one_nxt = alert_mask_one_r;
		alert_mask_two_nxt = alert_mask_two_r;
		config_three_nxt = config_three_r;
		timer_limit_nxt = timer_limit_r;
		config_four_nxt = config_four_r;
		if (reg_wr_in) begin
			case (reg_addr_in)
				ADDR_ALERT_MASK_ONE: alert_mask_one_nxt = reg_wdata_in;
				ADDR_ALERT_MASK_TWO: alert_mask_two_nxt = reg_wdata_in;
				ADDR_CONFIG_THREE: config_three_nxt = reg_wdata_in;
				ADDR_TIMER_LIMIT: timer_limit_nxt = reg_wdata_in;
				ADDR_CONFIG_FOUR: config_four_nxt = reg_wdata_in;
				default: ;
			endcase
		end
	end

	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd_in) begin
			case (reg_addr_in)
				ADDR_STATUS_ONE: rdata_nxt = {summary, status_one_r};
				ADDR_STATUS_TWO: rdata_nxt = status_two_r;
				ADDR_ALERT_MASK_ONE: rdata_nxt = alert_mask_one_r;
				ADDR_ALERT_MASK_TWO: rdata_nxt = alert_mask_two_r;
				ADDR_CONFIG_THREE: rdata_nxt = config_three_r;
				ADDR_THERMAL_TIMER: rdata_nxt = timer_value;
				ADDR_TIMER_LIMIT: rdata_nxt = timer_limit_r;
				ADDR_CONFIG_FOUR: rdata_nxt = config_four_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_comb begin
		// RULE_04 RULE_05 RULE_06 RULE_07 RULE_25 masks gate only the alert
		alert_nxt = |(status_one_r & ~alert_mask_one_r[6:0])
			|| (!alert_mask_one_r[SUMMARY_BIT] && |(status_two_r & ~alert_mask_two_r));
		// RULE_13 RULE_14 full_speed_on_thermal_input only for running fans
		full_speed_on_thermal_input_nxt = config_three_r[CFG3_FULL_SPEED_ON_THERMAL_INPUT_BIT] && thermal_asserted && fan_running_in;
		// RULE_09 RULE_02 pin carries alert or the second fan drive
		if (config_three_r[CFG3_ALERT_ON_PIN_BIT]) begin
			alert_pin_nxt = 1'b0;
			alert_oe_n_nxt = !alert_r;
		end else begin
			alert_pin_nxt = second_fan_drive_in;
			alert_oe_n_nxt = 1'b0;
		end
		// RULE_10 shared pin drives only as alert; other functions are inputs
		shared_oe_n_nxt = !(pin_fn == AMT_FN_ALERT && alert_r);
	end

	always_ff @(posedge clk_in) begin
		// RULE_08 alert function off after reset
		if (rst_in) begin
			status_one_r <= 7'h00;
			status_two_r <= 8'h00;
			alert_mask_one_r <= ALERT_MASK_ONE_RST;
			alert_mask_two_r <= ALERT_MASK_TWO_RST;
			config_three_r <= CONFIG_THREE_RST;
			timer_limit_r <= TIMER_LIMIT_RST;
			config_four_r <= CONFIG_FOUR_RST;
			rdata_r <= 8'h00;
			alert_r <= 1'b0;
			full_speed_on_thermal_input_r <= 1'b0;
			alert_pin_r <= 1'b0;
			alert_oe_n_r <= 1'b0;
			shared_oe_n_r <= 1'b1;
		end else if (ce_in) begin
			status_one_r <= status_one_nxt;
			status_two_r <= status_two_nxt;
			alert_mask_one_r <= alert_mask_one_nxt;
			alert_mask_two_r <= alert_mask_two_nxt;
			config_three_r <= config_three_nxt;
			timer_limit_r <= timer_limit_nxt;
			config_four_r <= config_four_nxt;
			rdata_r <= rdata_nxt;
			alert_r <= alert_nxt;
			full_speed_on_thermal_input_r <= full_speed_on_thermal_input_nxt;
			alert_pin_r <= alert_pin_nxt;
			alert_oe_n_r <= alert_oe_n_nxt;
			shared_oe_n_r <= shared_oe_n_nxt;
		end
	end

	assign reg_rdata_out = rdata_r;
	assign alert_pin_out = alert_pin_r;
	assign alert_pin_oe_n_out = alert_oe_n_r;
	// open drain: level is low whenever driven
	assign shared_pin_out = 1'b0;
	assign shared_pin_oe_n_out = shared_oe_n_r;
	assign full_speed_on_thermal_input_out = full_speed_on_thermal_input_r;
	assign shared_pin_function_field_out = pin_fn;

	property p_sticky;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && status_two_r[7] && !(reg_rd_in && reg_addr_in == ADDR_STATUS_TWO))
			|=> status_two_r[7];
	endproperty
	a_sticky: assert property (p_sticky) else $error("sticky bit lost"); // RULE_01

	property p_overtemp;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && !fault_two_in[OVERTEMP_BIT]) |=> !status_two_r[OVERTEMP_BIT];
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("overtemperature latched"); // RULE_03

	property p_mask_status;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && fault_one_in[6] && alert_mask_one_r[6]) |=> status_one_r[6];
	endproperty
	a_mask_status: assert property (p_mask_status) else $error("masked bit not set"); // RULE_04

	property p_alert;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && status_one_r[4] && !alert_mask_one_r[4]) |=> alert_r;
	endproperty
	a_alert: assert property (p_alert) else $error("alert not raised"); // RULE_25

	property p_summary_mask;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && status_one_r == 7'h00 && alert_mask_one_r[SUMMARY_BIT]) |=> !alert_r;
	endproperty
	a_summary_mask: assert property (p_summary_mask) else $error("summary mask leaked"); // RULE_05

	property p_full_speed_on_thermal_input;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && !fan_running_in) |=> !full_speed_on_thermal_input_out;
	endproperty
	a_full_speed_on_thermal_input: assert property (p_full_speed_on_thermal_input) else $error("full_speed_on_thermal_input on idle fan"); // RULE_14

	property p_pin_drive;
		@(posedge clk_in) disable iff (rst_in)
		(ce_in && !config_three_r[CFG3_ALERT_ON_PIN_BIT])
			|=> !alert_pin_oe_n_out && alert_pin_out == $past(second_fan_drive_in);
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("fan drive not passed"); // RULE_09

	property p_thermal_off;
		@(posedge clk_in) disable iff (rst_in)
		(!thermal_en && !timer_read) |=> $stable(timer_value);
	endproperty
	a_thermal_off: assert property (p_thermal_off) else $error("thermal active while off"); // RULE_12
endmodule

// >>> amt_host_model.sv
// amt_host_model: host side of the byte register port.
// assumes one-cycle strobes taken on the rising edge of clk_in.
`timescale 1ns/1ps
module amt_host_model (
	input wire logic clk_in,
	output logic reg_wr_out,
	output logic reg_rd_out,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	input wire logic [7:0] reg_rdata_in
);
	import amt_pkg::*;
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge clk_in);
		reg_wr_out <= 1'b0;
		// released lines flip so stale values never pass for data
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= a;
		@(posedge clk_in);
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~a;
		@(posedge clk_in);
		#1 d = reg_rdata_in;
	endtask
	task automatic timer_rd(output logic [7:0] d);
		logic [7:0] s;
		rd(ADDR_THERMAL_TIMER, d);
		rd(ADDR_STATUS_TWO, s);
	endtask
endmodule

// >>> alert_mask_thermal_timer_bench.sv
// alert_mask_thermal_timer_bench: register-level tests of alert and timer.
// assumes the timer unit shortened to 4 cycles.
`timescale 1ns/1ps
module alert_mask_thermal_timer_bench;
	import amt_pkg::*;
	localparam int LSB = 4;
	logic clk_in, rst_in, ce_in, reg_wr, reg_rd, thermal_event_pin_n, shared_in, fan_drv, fan_run;
	logic alert_pin, alert_oe_n, shared_out, shared_oe_n, full_speed_on_thermal_input;
	logic [7:0] addr, wdata, rdata, rv, fault_two, st;
	logic [6:0] fault_one;
	amt_pin_fn_e fn;
	int failures, n_tests, cycles, b;
	amt_host_model host (.clk_in(clk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata));
	amt_alert_ctrl #(.LSB_CYCLES(LSB)) dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_rdata_out(rdata), .fault_one_in(fault_one), .fault_two_in(fault_two),
		.thermal_event_pin_n_in(thermal_event_pin_n), .shared_pin_in(shared_in),
		.second_fan_drive_in(fan_drv), .fan_running_in(fan_run), .alert_pin_out(alert_pin),
		.alert_pin_oe_n_out(alert_oe_n), .shared_pin_out(shared_out),
		.shared_pin_oe_n_out(shared_oe_n), .full_speed_on_thermal_input_out(full_speed_on_thermal_input),
		.shared_pin_function_field_out(fn));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic results;
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// hang guard, well above the expected run of under 1800 cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			failures++;
			results();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, rv);
		chk(what, exp, rv);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic achk(input logic act);
		chk("alert_oe_n", {7'h00, !act}, {7'h00, alert_oe_n});
	endtask
	task automatic thermal_event_pin(input int n);
		@(posedge clk_in) thermal_event_pin_n <= 1'b0;
		repeat (n) @(posedge clk_in);
		thermal_event_pin_n <= 1'b1;
	endtask
	initial begin
		{failures, n_tests, cycles, b} = '0;
		{rst_in, ce_in, thermal_event_pin_n, shared_in} = 4'hF;
		{fan_drv, fan_run, fault_one, fault_two} = '0;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in) fan_drv <= 1'b1;
		tick(3);
		chk("pin10_oe_n", 8'h00, {7'h00, alert_oe_n});
		chk("pin10_fan", 8'h01, {7'h00, alert_pin});
		chk("pin14_oe_n", 8'h01, {7'h00, shared_oe_n});
		rchk("mask_one_rst", ADDR_ALERT_MASK_ONE, 8'h00);
		rchk("mask_two_rst", ADDR_ALERT_MASK_TWO, 8'h00);
		rchk("unmapped", 8'h30, 8'h00);
		host.wr(ADDR_ALERT_MASK_ONE, 8'hA5);
		host.wr(ADDR_ALERT_MASK_TWO, 8'h5A);
		rchk("mask_one_rw", ADDR_ALERT_MASK_ONE, 8'hA5);
		rchk("mask_two_rw", ADDR_ALERT_MASK_TWO, 8'h5A);
		host.wr(ADDR_ALERT_MASK_ONE, 8'h00);
		host.wr(ADDR_ALERT_MASK_TWO, 8'h00);
		host.wr(ADDR_CONFIG_THREE, 8'h01);
		tick(3);
		achk(1'b0);
		chk("pin10_alert", 8'h00, {7'h00, alert_pin});
		@(posedge clk_in) fault_one <= 7'h40;
		tick(3);
		achk(1'b1);
		rchk("st1_held", ADDR_STATUS_ONE, 8'h40);
		rchk("st1_still", ADDR_STATUS_ONE, 8'h40);
		@(posedge clk_in) fault_one <= 7'h00;
		tick(5);
		achk(1'b1);
		rchk("st1_read", ADDR_STATUS_ONE, 8'h40);
		tick(3);
		achk(1'b0);
		rchk("st1_clear", ADDR_STATUS_ONE, 8'h00);
		// each mask bit but mask one bit7 against its own source, then unmasked
		for (int k = 0; k < 15; k++) begin
			b = (k < 7) ? k : k - 7;
			st = (k < 7) ? ADDR_STATUS_ONE : ADDR_STATUS_TWO;
			host.wr((k < 7) ? ADDR_ALERT_MASK_ONE : ADDR_ALERT_MASK_TWO, 8'h01 << b);
			@(posedge clk_in) if (k < 7) fault_one <= 7'h01 << b; else fault_two <= 8'h01 << b;
			tick(3);
			achk(1'b0);
			rchk("st_masked", st, 8'h01 << b);
			if (k >= 7) rchk("st1_summary", ADDR_STATUS_ONE, 8'h80);
			@(posedge clk_in) {fault_one, fault_two} <= '0;
			host.wr((k < 7) ? ADDR_ALERT_MASK_ONE : ADDR_ALERT_MASK_TWO, 8'h00);
			tick(3);
			achk(k != 8);
			rchk("st_read", st, (k == 8) ? 8'h00 : 8'h01 << b);
			tick(3);
			achk(1'b0);
		end
		host.wr(ADDR_ALERT_MASK_ONE, 8'h80);
		@(posedge clk_in) fault_two <= 8'h08;
		tick(3);
		achk(1'b0);
		@(posedge clk_in) fault_two <= 8'h00;
		rchk("st2_fan", ADDR_STATUS_TWO, 8'h08);
		host.wr(ADDR_ALERT_MASK_ONE, 8'h00);
		host.wr(ADDR_CONFIG_THREE, 8'h07);
		host.wr(ADDR_TIMER_LIMIT, 8'h02);
		@(posedge clk_in) fan_run <= 1'b1;
		thermal_event_pin(1);
		tick(3);
		rchk("timer_first", ADDR_THERMAL_TIMER, 8'h01);
		rchk("timer_cleared", ADDR_THERMAL_TIMER, 8'h00);
		fork
			thermal_event_pin(10);
			begin
				tick(4);
				chk("full_speed_on_thermal_input_on", 8'h01, {7'h00, full_speed_on_thermal_input});
			end
		join
		tick(3);
		chk("full_speed_on_thermal_input_off", 8'h00, {7'h00, full_speed_on_thermal_input});
		achk(1'b0);
		@(posedge clk_in) fan_run <= 1'b0;
		tick(20);
		fork
			thermal_event_pin(12);
			begin
				tick(4);
				chk("full_speed_on_thermal_input_idle", 8'h00, {7'h00, full_speed_on_thermal_input});
			end
		join
		tick(3);
		achk(1'b1);
		rchk("timer_accum", ADDR_THERMAL_TIMER, 8'h05);
		rchk("st1_timer", ADDR_STATUS_ONE, 8'h01);
		thermal_event_pin(1100);
		tick(2);
		rchk("timer_full", ADDR_THERMAL_TIMER, 8'hFF);
		host.wr(ADDR_TIMER_LIMIT, 8'h00);
		rchk("st1_full", ADDR_STATUS_ONE, 8'h01);
		@(posedge clk_in) thermal_event_pin_n <= 1'b0;
		tick(30);
		host.rd(ADDR_THERMAL_TIMER, rv);
		rchk("timer_restart", ADDR_THERMAL_TIMER, 8'h01);
		@(posedge clk_in) thermal_event_pin_n <= 1'b1;
		rchk("st1_rearm", ADDR_STATUS_ONE, 8'h01);
		host.rd(ADDR_THERMAL_TIMER, rv);
		rchk("st1_sticky", ADDR_STATUS_ONE, 8'h01);
		rchk("st1_gone", ADDR_STATUS_ONE, 8'h00);
		host.wr(ADDR_CONFIG_THREE, 8'h00);
		// low pin level keeps io-six mode from setting status two here
		@(posedge clk_in) shared_in <= 1'b0;
		for (int f = 0; f < 4; f++) begin
			host.wr(ADDR_CONFIG_FOUR, 8'(f));
			tick(1);
			chk("pin14_fn", 8'(f), {6'h00, fn});
		end
		chk("pin14_idle", 8'h01, {7'h00, shared_oe_n});
		@(posedge clk_in) fault_one <= 7'h10;
		tick(3);
		chk("pin14_alert", 8'h00, {7'h00, shared_oe_n});
		chk("pin10_fan", 8'h01, {7'h00, alert_pin});
		@(posedge clk_in) fault_one <= 7'h00;
		host.rd(ADDR_STATUS_ONE, rv);
		host.wr(ADDR_CONFIG_FOUR, 8'h01);
		@(posedge clk_in) shared_in <= 1'b0;
		thermal_event_pin(10);
		@(posedge clk_in) shared_in <= 1'b1;
		rchk("timer_off", ADDR_THERMAL_TIMER, 8'h00);
		host.wr(ADDR_CONFIG_THREE, 8'h02);
		@(posedge clk_in) shared_in <= 1'b0;
		tick(10);
		@(posedge clk_in) shared_in <= 1'b1;
		rchk("st2_thermal", ADDR_STATUS_TWO, 8'h20);
		host.timer_rd(rv);
		chk("timer_shared", 8'h02, rv);
		rchk("st2_cleared", ADDR_STATUS_TWO, 8'h00);
		// clock enable low must freeze the timer during an assertion
		@(posedge clk_in) {ce_in, thermal_event_pin_n} <= 2'b00;
		tick(20);
		@(posedge clk_in) {ce_in, thermal_event_pin_n} <= 2'b11;
		rchk("timer_frozen", ADDR_THERMAL_TIMER, 8'h00);
		host.wr(ADDR_ALERT_MASK_TWO, 8'h20);
		host.wr(ADDR_CONFIG_THREE, 8'h03);
		host.wr(ADDR_CONFIG_FOUR, 8'h02);
		tick(3);
		achk(1'b0);
		rchk("st2_gpio", ADDR_STATUS_TWO, 8'h20);
		results();
	end
endmodule
